// ==== verilog/pis_pkg.sv ====
// What this block does
// RULE1: Self test and memory check come first.
// RULE2: Second, strap sets the bus slave address.
// RULE3: Third, voltage strap loads the setpoint word.
// RULE4: Fourth, factory defaults overwrite working memory.
// RULE5: Fifth, user values overwrite working memory.
// RULE6: Last, detect sync clock and lock to it.
// RULE7: Enable and bus honoured only after init time.
// RULE8: Host can write-protect single commands.
// RULE9: Turn-on above turn-off; below turn-off faults.
// RULE10: Latch-off keeps output off until clear.
// RULE11: Auto-recovery restarts once input exceeds turn-on.
// RULE12: Auto-recovery is the default response.
// RULE13: Undervolt thresholds and response from commands.
// RULE14: Current sharing always forces latch-off.
// RULE15: Overvolt supervised continuously, same responses.
// RULE16: Overvolt thresholds and response from commands.
// RULE17: Oversampled dual-edge PWM, duty per sample.
// RULE18: Host keeps gain factor near 200 to 600.
// RULE19: Host keeps residual 70-120, never above 127.
// RULE20: Ignore enable and bus during initialization.
package pis_pkg;
	localparam int DW = 24;
	localparam int IW = 4;
	localparam int VW = 16;
	localparam int NCMD = 10;
	// Command indices, also the register offsets on the plain port.
	localparam logic [IW-1:0] CMD_VOUT = 4'h0;
	localparam logic [IW-1:0] CMD_UV_FAULT = 4'h1;
	localparam logic [IW-1:0] CMD_UV_WARN = 4'h2;
	localparam logic [IW-1:0] CMD_UV_RESP = 4'h3;
	localparam logic [IW-1:0] CMD_OV_FAULT = 4'h4;
	localparam logic [IW-1:0] CMD_OV_WARN = 4'h5;
	localparam logic [IW-1:0] CMD_OV_RESP = 4'h6;
	localparam logic [IW-1:0] CMD_LOOP_CFG = 4'h7;
	localparam logic [IW-1:0] CMD_PROTECT = 4'h8;
	localparam logic [IW-1:0] CMD_MODE = 4'h9;
	localparam logic [IW-1:0] CMD_LAST = 4'h9;
	localparam logic [IW-1:0] REG_CLEAR = 4'ha;
	localparam logic [IW-1:0] REG_STATUS = 4'hb;
	localparam logic [IW-1:0] NVM_SIG_IDX = 4'hf;
	// Fault response codes; any code other than latch means auto unless current sharing is on.
	localparam logic [DW-1:0] RESP_LATCH = 24'h000000;
	localparam logic [DW-1:0] RESP_AUTO = 24'h000002;
	localparam int MODE_SHARE_BIT = 0;
	localparam int GAIN_LSB = 0;
	localparam int GAIN_W = 10;
	localparam int RES_LSB = 12;
	localparam int RES_W = 7;
	// Status word layout, low bit first.
	localparam int STS_ADDR_LSB = 8;
	localparam int STS_ADDR_W = 7;
	localparam int STS_PAD_W = DW - STS_ADDR_LSB - STS_ADDR_W;
	localparam logic [6:0] ADDR_BASE = 7'h20;
	// Signature of a healthy image; the value is arbitrary.
	localparam logic [DW-1:0] NVM_SIGNATURE = 24'h00a5c3;
	// Reset and image values, millivolts for voltages.
	localparam logic [DW-1:0] DEF_VOUT = 24'h0003e8;
	localparam logic [DW-1:0] USER_VOUT = 24'h0004b0;
	localparam logic [DW-1:0] DEF_UV_FAULT = 24'h001b58;
	localparam logic [DW-1:0] DEF_UV_WARN = 24'h001ce8;
	localparam logic [DW-1:0] DEF_OV_FAULT = 24'h0039d0;
	localparam logic [DW-1:0] DEF_OV_WARN = 24'h003840;
	localparam logic [DW-1:0] DEF_LOOP_CFG = 24'h05a12c;
	localparam logic [DW-1:0] DEF_ZERO = 24'h000000;
	// Timing.
	localparam int CLK_HZ = 10_000_000;
	localparam int INIT_TIME_US = 100;
	localparam int INIT_CYC = (INIT_TIME_US * CLK_HZ + 999_999) / 1_000_000;
	localparam int SYNC_WIN_CYC = 64;
	localparam logic [3:0] SYNC_MIN_EDGES = 4'h4;
	localparam logic [1:0] SYNC_DIV_LAST = 2'h3;
	localparam logic [3:0] TRI_TOP = 4'hf;
	localparam logic [2:0] SAMPLE_LAST = 3'h7;
	localparam logic signed [21:0] ACC_MAX = 22'sh007fff;

	// Output voltage strap code to millivolts; code 0 is a short.
	function automatic logic [DW-1:0] vset_mv(input logic [4:0] c);
		logic [DW-1:0] k;
		k = {19'h00000, c};
		if (c == 5'h00) begin
			vset_mv = 24'h0003e8;
		end else if (c <= 5'h0c) begin
			vset_mv = 24'h000226 + 24'h000032 * k;
		end else if (c <= 5'h0f) begin
			vset_mv = 24'h0004b0 + 24'h000032 * (k - 24'h00000d);
		end else if (c <= 5'h14) begin
			vset_mv = 24'h000578 + 24'h000064 * (k - 24'h000010);
		end else begin
			vset_mv = 24'h0004b0;
		end
	endfunction
endpackage

// ==== verilog/pis_nvm.sv ====
`timescale 1ns/10ps
`default_nettype none
module pis_nvm (
	input wire logic sys_clk,
	input wire logic rd_en,
	input wire logic area_user,
	input wire logic [pis_pkg::IW-1:0] rd_idx,
	output logic [pis_pkg::DW-1:0] rd_data_r
);
	import pis_pkg::*;

	// Both areas are constant images; only the output setpoint differs.
	function automatic logic [DW-1:0] image(input logic user,
		input logic [IW-1:0] i);
		if (i == CMD_VOUT) begin
			image = user ? USER_VOUT : DEF_VOUT;
		end else if (i == CMD_UV_FAULT) begin
			image = DEF_UV_FAULT;
		end else if (i == CMD_UV_WARN) begin
			image = DEF_UV_WARN;
		end else if (i == CMD_UV_RESP || i == CMD_OV_RESP) begin
			image = RESP_AUTO;
		end else if (i == CMD_OV_FAULT) begin
			image = DEF_OV_FAULT;
		end else if (i == CMD_OV_WARN) begin
			image = DEF_OV_WARN;
		end else if (i == CMD_LOOP_CFG) begin
			image = DEF_LOOP_CFG;
		end else if (i == NVM_SIG_IDX) begin
			image = NVM_SIGNATURE;
		end else begin
			image = DEF_ZERO;
		end
	endfunction

	// Read data come from a register, one cycle after the request.
	always_ff @(posedge sys_clk) begin
		if (rd_en) begin
			rd_data_r <= image(area_user, rd_idx);
		end
	end
endmodule // pis_nvm
`default_nettype wire

// ==== verilog/pis_dpwm.sv ====
`timescale 1ns/10ps
`default_nettype none
module pis_dpwm (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic run,
	input wire logic sync_align,
	input wire logic [pis_pkg::VW-1:0] vref,
	input wire logic [pis_pkg::VW-1:0] vout_adc,
	input wire logic [pis_pkg::GAIN_W-1:0] gain,
	input wire logic [pis_pkg::RES_W-1:0] residual,
	output logic pwm_hi,
	output logic sample_pulse
);
	import pis_pkg::*;
	logic [3:0] tri_r;
	logic up_r;
	logic [2:0] samp_r;
	logic [4:0] duty_r;
	logic signed [20:0] acc_r;
	logic signed [16:0] err;
	logic signed [27:0] prod1;
	logic signed [35:0] prod2;
	logic signed [20:0] step;
	logic signed [21:0] acc_sum;
	logic signed [20:0] acc_nxt;
	logic [4:0] duty_nxt;

	// Correction per sample: error times gain, scaled by the residual.
	assign err = $signed({1'b0, vref}) - $signed({1'b0, vout_adc});
	assign prod1 = err * $signed({1'b0, gain});
	assign prod2 = prod1 * $signed({1'b0, residual});
	assign step = prod2[35:15];
	assign acc_sum = $signed({acc_r[20], acc_r}) + $signed({step[20], step});
	assign acc_nxt = acc_sum[21] ? 21'sh000000 :
		(acc_sum > ACC_MAX) ? ACC_MAX[20:0] : acc_sum[20:0];
	assign duty_nxt = acc_nxt[15:11];
	// RULE17: four samples per period
	assign sample_pulse = (samp_r == SAMPLE_LAST);
	// Both edges move because the carrier is a triangle.
	assign pwm_hi = run && ({1'b0, tri_r} < duty_r);

	// Triangle carrier, 32 cycles a period, restarted by the sync lock.
	always_ff @(posedge sys_clk) begin
		if (reset || sync_align) begin
			tri_r <= 4'h0;
			up_r <= 1'b1;
			samp_r <= 3'h0;
		end else begin
			samp_r <= samp_r + 3'h1;
			if (up_r) begin
				tri_r <= (tri_r == TRI_TOP) ? tri_r : tri_r + 4'h1;
				up_r <= (tri_r != TRI_TOP);
			end else begin
				tri_r <= (tri_r == 4'h0) ? tri_r : tri_r - 4'h1;
				up_r <= (tri_r == 4'h0);
			end
		end
	end

	// RULE17: duty after every sample
	// The integrator is cleared while off so it cannot wind up.
	always_ff @(posedge sys_clk) begin
		if (reset || !run) begin
			acc_r <= 21'sh000000;
			duty_r <= 5'h00;
		end else if (sample_pulse) begin
			acc_r <= acc_nxt;
			duty_r <= duty_nxt;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	property p_duty_update;
		sample_pulse && run |=> duty_r == $past(duty_nxt);
	endproperty
	a_duty_update: assert property (p_duty_update) // RULE17
		else $error("duty not taken at sample");
	property p_sample_gap;
		sample_pulse |=> (!sample_pulse) [*7];
	endproperty
	a_sample_gap: assert property (p_sample_gap) // RULE17
		else $error("samples closer than eight cycles");
	// The first lock can land mid-grid and stretch one gap once.
	property p_sample_rate;
		sample_pulse && !sync_align |->
			##[1:8] (sample_pulse || sync_align);
	endproperty
	a_sample_rate: assert property (p_sample_rate) // RULE17
		else $error("sample missing within eight cycles");
	// After a restart of the carrier the next sample is exactly on time.
	property p_align_sample;
		sync_align |-> ##8 sample_pulse;
	endproperty
	a_align_sample: assert property (p_align_sample) // RULE17
		else $error("no sample eight cycles after realignment");
endmodule // pis_dpwm
`default_nettype wire

// ==== verilog/pis_supervisor.sv ====
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module pis_supervisor (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic en_pin,
	input wire logic sync_pin,
	input wire logic [5:0] addr_strap,
	input wire logic [4:0] vset_strap,
	input wire logic [pis_pkg::VW-1:0] vin_level,
	input wire logic [pis_pkg::VW-1:0] vout_adc,
	input wire logic [pis_pkg::IW-1:0] reg_addr,
	input wire logic [pis_pkg::DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pis_pkg::DW-1:0] reg_rdata_r,
	output logic [6:0] slave_addr_r,
	output logic init_done,
	output logic output_on_r,
	output logic pwm_hi,
	output logic sample_pulse
);
	import pis_pkg::*;
	typedef enum logic [3:0] {
		ST_SELF_RD, ST_SELF_CHK, ST_ADDR, ST_VSET, ST_DEF,
		ST_USER, ST_SYNC, ST_WAIT, ST_RUN
	} pis_state_t;

	pis_state_t state_r, state_nxt;
	logic [12:0] pin_s1_r, pin_s2_r;
	logic sync_prev_r, en_prev_r;
	logic [9:0] cnt_r;
	logic [IW-1:0] idx_r, ld_idx_r;
	logic ld_valid_r, nvm_err_r, sync_lock_r;
	logic [3:0] edge_cnt_r;
	logic [1:0] div_r;
	logic uv_latch_r, uv_hold_r, ov_latch_r, ov_hold_r;
	logic [DW-1:0] work_r [NCMD];
	logic [DW-1:0] nvm_data;

	// Enable, sync and strap pins pass two flip-flops before anything reads them.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pin_s1_r <= 13'h0000;
			pin_s2_r <= 13'h0000;
		end else begin
			pin_s1_r <= {en_pin, sync_pin, addr_strap, vset_strap};
			pin_s2_r <= pin_s1_r;
		end
	end

	wire en_s = pin_s2_r[12];
	wire sync_s = pin_s2_r[11];
	wire [5:0] addr_s = pin_s2_r[10:5];
	wire [4:0] vset_s = pin_s2_r[4:0];
	wire sync_edge = sync_s && !sync_prev_r;
	wire [6:0] addr_calc = ADDR_BASE + {1'b0, addr_s};
	wire [DW-1:0] vset_word = vset_mv(vset_s);
	wire sync_win_end = (cnt_r == 10'(SYNC_WIN_CYC - 1));
	wire init_end = (cnt_r == 10'(INIT_CYC - 1));
	wire idx_end = (idx_r == CMD_LAST);

	// RULE1: self test leads
	// Steps run strictly in order; nothing skips ahead.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_SELF_RD: state_nxt = ST_SELF_CHK;
			ST_SELF_CHK: state_nxt = ST_ADDR;
			ST_ADDR: state_nxt = ST_VSET;
			ST_VSET: state_nxt = ST_DEF;
			ST_DEF: state_nxt = idx_end ? ST_USER : ST_DEF;
			ST_USER: state_nxt = idx_end ? ST_SYNC : ST_USER;
			ST_SYNC: state_nxt = sync_win_end ? ST_WAIT : ST_SYNC;
			ST_WAIT: state_nxt = init_end ? ST_RUN : ST_WAIT;
			default: state_nxt = ST_RUN;
		endcase
	end

	// Two counters: idx_r serves as load index, cnt_r as sync window and init timer.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_r <= ST_SELF_RD;
			cnt_r <= 10'h000;
			idx_r <= 4'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= (state_nxt != state_r) ? 10'h000 : cnt_r + 10'h001;
			idx_r <= (state_nxt != state_r) ? 4'h0 : idx_r + 4'h1;
		end
	end

	// NVM reads: the signature first, then each area in turn.
	wire nvm_rd = (state_r == ST_SELF_RD) || (state_r == ST_DEF) ||
		(state_r == ST_USER);
	wire [IW-1:0] nvm_idx = (state_r == ST_SELF_RD) ? NVM_SIG_IDX : idx_r;

	pis_nvm u_nvm (
		.sys_clk(sys_clk),
		.rd_en(nvm_rd),
		.area_user(state_r == ST_USER),
		.rd_idx(nvm_idx),
		.rd_data_r(nvm_data)
	);

	// RULE1: memory check
	// A bad image is flagged but the sequence carries on.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			nvm_err_r <= 1'b0;
			ld_valid_r <= 1'b0;
			ld_idx_r <= 4'h0;
		end else begin
			ld_valid_r <= (state_r == ST_DEF) || (state_r == ST_USER);
			ld_idx_r <= idx_r;
			if (state_r == ST_SELF_CHK) begin
				nvm_err_r <= (nvm_data != NVM_SIGNATURE);
			end
		end
	end

	// RULE2: address from strap
	// Straps are read once; later changes are not seen.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			slave_addr_r <= 7'h00;
		end else if (state_r == ST_ADDR) begin
			slave_addr_r <= addr_calc;
		end
	end

	// Bus decode; nothing is accepted before the sequence ends.
	wire bus_ready = (state_r == ST_RUN);
	assign init_done = bus_ready;
	wire cmd_hit = (reg_addr <= CMD_LAST);
	wire prot_bit = work_r[CMD_PROTECT][reg_addr];
	wire prot_block = prot_bit && (reg_addr != CMD_PROTECT);
	// RULE20: bus ignored early
	wire bus_wr_ok = bus_ready && reg_wr && cmd_hit && !prot_block;
	wire clear_wr = bus_ready && reg_wr && (reg_addr == REG_CLEAR);

	// RULE4: defaults then user
	// Loads, strap and bus never write in the same cycle.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			for (int i = 0; i < NCMD; i++) begin
				work_r[i] <= DEF_ZERO;
			end
		end else if (ld_valid_r) begin
			// RULE5: user overrides all
			work_r[ld_idx_r] <= nvm_data;
		end else if (state_r == ST_VSET) begin
			// RULE3: strap setpoint
			work_r[CMD_VOUT] <= vset_word;
		end else if (bus_wr_ok) begin
			// RULE7: bus write replaces
			work_r[reg_addr] <= reg_wdata;
		end
	end

	// RULE6: sync detect
	// Enough edges inside the window means a clock is present.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sync_prev_r <= 1'b0;
			edge_cnt_r <= 4'h0;
			sync_lock_r <= 1'b0;
			div_r <= 2'h0;
		end else begin
			sync_prev_r <= sync_s;
			if (state_r == ST_SYNC && sync_edge && edge_cnt_r != 4'hf) begin
				edge_cnt_r <= edge_cnt_r + 4'h1;
			end
			if (state_r == ST_SYNC && sync_win_end) begin
				sync_lock_r <= (edge_cnt_r >= SYNC_MIN_EDGES);
			end
			if (sync_lock_r && sync_edge) begin
				div_r <= div_r + 2'h1;
			end
		end
	end

	// RULE6: lock the carrier
	wire sync_align = sync_lock_r && sync_edge && (div_r == SYNC_DIV_LAST);

	// RULE14: sharing forces latch
	// RULE12: auto unless latch code
	function automatic logic resp_latch(input logic [DW-1:0] r,
		input logic share);
		resp_latch = share || (r == RESP_LATCH);
	endfunction

	// RULE13: undervolt limits
	// RULE16: overvolt limits
	wire share = work_r[CMD_MODE][MODE_SHARE_BIT];
	wire [VW-1:0] uv_off_lim = work_r[CMD_UV_FAULT][VW-1:0];
	wire [VW-1:0] uv_on_lim = work_r[CMD_UV_WARN][VW-1:0];
	wire [VW-1:0] ov_off_lim = work_r[CMD_OV_FAULT][VW-1:0];
	wire [VW-1:0] ov_on_lim = work_r[CMD_OV_WARN][VW-1:0];
	wire uv_mode_latch = resp_latch(work_r[CMD_UV_RESP], share);
	wire ov_mode_latch = resp_latch(work_r[CMD_OV_RESP], share);
	// RULE9: hysteresis thresholds
	wire uv_trip = bus_ready && (vin_level < uv_off_lim);
	wire uv_on_ok = (vin_level > uv_on_lim);
	// RULE15: overvolt trip
	wire ov_trip = bus_ready && (vin_level > ov_off_lim);
	wire ov_on_ok = (vin_level < ov_on_lim);

	// RULE7: enable after init
	wire en_eff = bus_ready && en_s;
	wire en_rise = en_eff && !en_prev_r;
	wire fault_clr = clear_wr || en_rise;
	// RULE10: latch until clear
	// A trip in the clearing cycle wins over the clear.
	wire uv_latch_nxt = (uv_trip && uv_mode_latch) || (uv_latch_r && !fault_clr);
	wire ov_latch_nxt = (ov_trip && ov_mode_latch) || (ov_latch_r && !fault_clr);
	// RULE11: auto recovery
	wire uv_hold_nxt = (uv_trip && !uv_mode_latch) || (uv_hold_r && !uv_on_ok);
	wire ov_hold_nxt = (ov_trip && !ov_mode_latch) || (ov_hold_r && !ov_on_ok);
	wire any_fault = uv_latch_nxt || ov_latch_nxt || uv_hold_nxt || ov_hold_nxt;

	// Output switches off on the edge after the input crosses a limit.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			{uv_latch_r, ov_latch_r, uv_hold_r, ov_hold_r} <= 4'h0;
			en_prev_r <= 1'b0;
			output_on_r <= 1'b0;
		end else begin
			{uv_latch_r, ov_latch_r} <= {uv_latch_nxt, ov_latch_nxt};
			{uv_hold_r, ov_hold_r} <= {uv_hold_nxt, ov_hold_nxt};
			en_prev_r <= en_eff;
			output_on_r <= en_eff && !any_fault;
		end
	end

	// Read data stand for one cycle only; unmapped offsets read zero.
	wire [DW-1:0] status_w = {{STS_PAD_W{1'b0}}, slave_addr_r, nvm_err_r,
		sync_lock_r, ov_hold_r, uv_hold_r, ov_latch_r, uv_latch_r,
		output_on_r, init_done};
	wire [DW-1:0] rd_word = cmd_hit ? work_r[reg_addr] :
		(reg_addr == REG_STATUS) ? status_w : DEF_ZERO;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reg_rdata_r <= DEF_ZERO;
		end else begin
			reg_rdata_r <= (bus_ready && reg_rd) ? rd_word : DEF_ZERO;
		end
	end

	// RULE19: residual field is seven bits
	// RULE18: gain taken as written
	pis_dpwm u_dpwm (
		.sys_clk(sys_clk),
		.reset(reset),
		.run(output_on_r),
		.sync_align(sync_align),
		.vref(work_r[CMD_VOUT][VW-1:0]),
		.vout_adc(vout_adc),
		.gain(work_r[CMD_LOOP_CFG][GAIN_LSB +: GAIN_W]),
		.residual(work_r[CMD_LOOP_CFG][RES_LSB +: RES_W]),
		.pwm_hi(pwm_hi),
		.sample_pulse(sample_pulse)
	);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence s_def_done;
		state_r == ST_DEF && idx_end;
	endsequence
	sequence s_user_walk;
		(state_r == ST_USER) [*8];
	endsequence
	property p_selftest_first;
		state_r == ST_ADDR |-> $past(state_r) == ST_SELF_CHK;
	endproperty
	a_selftest_first: assert property (p_selftest_first) // RULE1
		else $error("address step before self test");
	property p_addr_derive;
		state_r == ST_ADDR |=> slave_addr_r == $past(addr_calc);
	endproperty
	a_addr_derive: assert property (p_addr_derive) // RULE2
		else $error("slave address not from strap");
	property p_vset_load;
		state_r == ST_VSET |=> work_r[CMD_VOUT] == $past(vset_word);
	endproperty
	a_vset_load: assert property (p_vset_load) // RULE3
		else $error("strap setpoint not loaded");
	property p_nvm_copy;
		ld_valid_r && ld_idx_r == CMD_VOUT |=>
			work_r[CMD_VOUT] == $past(nvm_data);
	endproperty
	a_nvm_copy: assert property (p_nvm_copy) // RULE4
		else $error("nvm word not copied");
	property p_user_after_def;
		s_def_done |=> s_user_walk;
	endproperty
	a_user_after_def: assert property (p_user_after_def) // RULE5
		else $error("user load does not follow defaults");
	property p_sync_lock;
		state_r == ST_SYNC && sync_win_end && edge_cnt_r >= SYNC_MIN_EDGES
			|=> sync_lock_r && state_r == ST_WAIT;
	endproperty
	a_sync_lock: assert property (p_sync_lock) // RULE6
		else $error("sync clock not locked");
	property p_no_enable_early;
		!bus_ready |=> !output_on_r;
	endproperty
	a_no_enable_early: assert property (p_no_enable_early) // RULE7
		else $error("output on before init done");
	property p_no_read_early;
		reg_rd && !bus_ready |=> reg_rdata_r == DEF_ZERO;
	endproperty
	a_no_read_early: assert property (p_no_read_early) // RULE20
		else $error("bus answered during init");
	property p_protect;
		bus_ready && reg_wr && reg_addr == CMD_VOUT && prot_bit
			|=> $stable(work_r[CMD_VOUT]);
	endproperty
	a_protect: assert property (p_protect) // RULE8
		else $error("protected command was written");
	property p_uv_latch;
		uv_trip && uv_mode_latch |=> uv_latch_r && !output_on_r
			##1 (uv_latch_r || $past(fault_clr));
	endproperty
	a_uv_latch: assert property (p_uv_latch) // RULE10
		else $error("latch-off did not hold output off");
	property p_uv_auto;
		uv_hold_r && uv_on_ok |=> !uv_hold_r;
	endproperty
	a_uv_auto: assert property (p_uv_auto) // RULE11
		else $error("auto recovery did not release");
	property p_share;
		uv_trip && share |=> uv_latch_r && !uv_hold_r;
	endproperty
	a_share: assert property (p_share) // RULE14
		else $error("sharing mode did not latch");
	property p_ov;
		ov_trip |=> (ov_latch_r || ov_hold_r) && !output_on_r;
	endproperty
	a_ov: assert property (p_ov) // RULE15
		else $error("overvolt did not shut down");
endmodule // pis_supervisor
`default_nettype wire

// ==== tb/pis_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// The system side: a free-running sync oscillator and the enable logic.
module pis_host_model (
	input wire logic en_req,
	output logic sync_pin,
	output logic en_pin
);
	// sync clock
	// The oscillator runs free, so it is stable before any enable.
	initial begin
		sync_pin = 1'b0;
		forever #400 sync_pin = ~sync_pin;
	end
	// enable after init
	// The enable is a plain level; the device decides when to honour it.
	assign en_pin = en_req;
endmodule // pis_host_model
`default_nettype wire

// ==== tb/pis_supervisor_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module pis_supervisor_tb;
	import pis_pkg::*;
	logic sys_clk = 1'b0, reset = 1'b1, en_req = 1'b1;
	logic en_pin, sync_pin, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [5:0] addr_strap = 6'h05;
	logic [4:0] vset_strap = 5'h03;
	logic [VW-1:0] vin_level = 16'h2ee0, vout_adc = 16'h044c;
	logic [IW-1:0] reg_addr = 4'h0;
	logic [DW-1:0] reg_wdata = 24'h000000, rd;
	logic [DW-1:0] reg_rdata_r;
	logic [6:0] slave_addr_r;
	logic init_done, output_on_r, pwm_hi, sample_pulse;
	int err_total = 0, checks = 0, n, pw;

	pis_host_model host (.en_req(en_req), .sync_pin(sync_pin),
		.en_pin(en_pin));
	pis_supervisor dut (.sys_clk(sys_clk), .reset(reset), .en_pin(en_pin),
		.sync_pin(sync_pin), .addr_strap(addr_strap),
		.vset_strap(vset_strap), .vin_level(vin_level),
		.vout_adc(vout_adc), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
		.slave_addr_r(slave_addr_r), .init_done(init_done),
		.output_on_r(output_on_r), .pwm_hi(pwm_hi),
		.sample_pulse(sample_pulse));

	always #50 sys_clk = ~sys_clk;

	task automatic chk(input string nm, input logic [DW-1:0] seen,
		input logic [DW-1:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One strobe cycle each; read data is taken in the cycle after.
	task automatic wr(input logic [IW-1:0] a, input logic [DW-1:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rdc(input string nm, input logic [IW-1:0] a,
		input logic [DW-1:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(nm, reg_rdata_r, exp);
	endtask

	task automatic vin(input logic [VW-1:0] v);
		@(posedge sys_clk);
		vin_level <= v;
	endtask

	// Bounded wait for the output to reach a level, then compare.
	task automatic wait_on(input string nm, input logic v, input int lim);
		for (int i = 0; i < lim && output_on_r !== v; i++) begin
			@(posedge sys_clk);
			#1;
		end
		chk(nm, {23'h0, output_on_r}, {23'h0, v});
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		err_total++;
		print_verdict();
	end

	initial begin
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		// Requests during the sequence are dropped and read as zero.
		wr(CMD_VOUT, 24'h000111);
		rdc("early read", CMD_VOUT, 24'h000000);
		chk("early output", {23'h0, output_on_r}, 24'h0);
		n = 4;
		while (init_done !== 1'b1 && n < 1200) begin
			@(posedge sys_clk);
			#1 n++;
		end
		chk("init time", {23'h0, n >= 1087 && n <= 1090}, 24'h1);
		chk("slave address", {17'h0, slave_addr_r}, 24'h25);
		// User image wins over strap and defaults.
		rdc("vout", CMD_VOUT, USER_VOUT);
		rdc("uv fault", CMD_UV_FAULT, DEF_UV_FAULT);
		rdc("uv warn", CMD_UV_WARN, DEF_UV_WARN);
		rdc("uv resp", CMD_UV_RESP, RESP_AUTO);
		rdc("ov resp", CMD_OV_RESP, RESP_AUTO);
		rdc("ov warn", CMD_OV_WARN, DEF_OV_WARN);
		rdc("status", REG_STATUS, 24'h002543);
		rdc("unmapped", 4'hc, 24'h000000);
		wait_on("enable", 1'b1, 8);
		// Host keeps gain 400 and residual 100 inside the usual ranges.
		wr(CMD_LOOP_CFG, 24'h064190);
		rdc("loop cfg", CMD_LOOP_CFG, 24'h064190);
		wr(CMD_VOUT, 24'h000500);
		rdc("vout write", CMD_VOUT, 24'h000500);
		wr(CMD_PROTECT, 24'h000001);
		wr(CMD_VOUT, 24'h000600);
		rdc("protected", CMD_VOUT, 24'h000500);
		wr(CMD_PROTECT, 24'h000000);
		// Duty is refreshed four times per carrier period.
		n = 0;
		pw = 0;
		// Long enough that the slow integrator has lifted the duty above zero.
		repeat (128) begin
			@(posedge sys_clk);
			#1 n += sample_pulse;
			pw |= pwm_hi;
		end
		chk("samples", 24'(n), 24'h000010);
		chk("pwm", 24'(pw), 24'h000001);
		// Auto recovery with hysteresis between the two limits.
		vin(16'h1770);
		wait_on("uv off", 1'b0, 3);
		vin(16'h1b9e);
		repeat (8) @(posedge sys_clk);
		#1 chk("uv band", {23'h0, output_on_r}, 24'h0);
		vin(16'h1f40);
		wait_on("uv back", 1'b1, 3);
		// Latch-off holds after recovery until a clear.
		wr(CMD_UV_RESP, RESP_LATCH);
		vin(16'h1770);
		vin(16'h2ee0);
		repeat (8) @(posedge sys_clk);
		#1 chk("latched", {23'h0, output_on_r}, 24'h0);
		wr(REG_CLEAR, 24'h000000);
		wait_on("cleared", 1'b1, 4);
		// Overvolt follows the same auto response.
		vin(16'h3a98);
		wait_on("ov off", 1'b0, 3);
		vin(16'h3908);
		repeat (8) @(posedge sys_clk);
		#1 chk("ov band", {23'h0, output_on_r}, 24'h0);
		vin(16'h2ee0);
		wait_on("ov back", 1'b1, 3);
		// Current sharing forces latch-off despite auto response.
		wr(CMD_UV_RESP, RESP_AUTO);
		wr(CMD_MODE, 24'h000001);
		vin(16'h1770);
		vin(16'h2ee0);
		repeat (8) @(posedge sys_clk);
		#1 chk("share", {23'h0, output_on_r}, 24'h0);
		wr(CMD_MODE, 24'h000000);
		wr(REG_CLEAR, 24'h000000);
		wait_on("share clear", 1'b1, 4);
		// Overvolt latch-off is released by enabling the output again.
		wr(CMD_OV_RESP, RESP_LATCH);
		vin(16'h3a98);
		vin(16'h2ee0);
		repeat (8) @(posedge sys_clk);
		#1 chk("ov latched", {23'h0, output_on_r}, 24'h0);
		rdc("ov status", REG_STATUS, 24'h002549);
		@(posedge sys_clk);
		en_req <= 1'b0;
		repeat (4) @(posedge sys_clk);
		en_req <= 1'b1;
		wait_on("reenable", 1'b1, 6);
		print_verdict();
	end
endmodule // pis_supervisor_tb
`default_nettype wire
